// file: hw/col_pkg.sv
// package: register map, field layout, reset values and timing counts of the offset loop block
package col_pkg;

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LOOP   = 8'h04;
    localparam logic [7:0] ADDR_GAIN   = 8'h08;
    localparam logic [7:0] ADDR_CLAMP  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_STANDBY_BIT = 0;
    localparam int CTRL_TEST_BIT    = 1;
    localparam int CTRL_GRAY_BIT    = 2;
    localparam int CTRL_LOW_BITS_INVERT_BIT    = 3;
    localparam int CTRL_TOP_BIT_INVERT_BIT    = 4;
    localparam int CTRL_PBINV_BIT   = 5;
    localparam int CTRL_DIRECT_BIT  = 6;
    localparam int LOOP_GAIN_LSB    = 0;
    localparam int LOOP_EXIT_LSB    = 2;
    localparam int STAT_DAC_LSB     = 16;
    localparam int STAT_ERR_LSB     = 4;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [6:0]  CTRL_RESET  = 7'h01;
    localparam logic [3:0]  LOOP_RESET  = 4'h0;
    localparam logic [7:0]  GAIN_RESET  = 8'h00;
    localparam logic [9:0]  CLAMP_RESET = 10'h040;

    // ************************************************************
    // output coding and loop constants
    // ************************************************************
    localparam logic [9:0]  TEST_PATTERN   = 10'h355;
    localparam logic [9:0]  LOW_MASK       = 10'h1ff;
    localparam logic [9:0]  TOP_MASK       = 10'h200;
    localparam logic [10:0] ERR_THRESHOLD  = 11'h020;
    localparam logic [3:0]  OB_FIRST_CLK   = 4'h5;
    localparam logic [3:0]  OB_LAST_CLK    = 4'hc;
    localparam int          OB_AVG_SHIFT   = 3;
    localparam int          PIPE_DEPTH     = 10;
    localparam int          TAP_CORR       = 9;
    localparam int          TAP_DIRECT     = 8;
    localparam logic signed [15:0] DAC_MAX = 16'sh07ff;
    localparam logic signed [15:0] DAC_MIN = -16'sh0800;
    localparam logic [11:0] DAC_MID        = 12'h800;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {ST_NORMAL, ST_CATCHUP, ST_EXIT} col_loop_state_t;

    // output formatting controls travel together
    typedef struct packed {
        logic direct_mode;
        logic preblank_pol_inv;
        logic top_bit_invert;
        logic low_bits_invert;
        logic gray_code_sel;
        logic test_pattern_sel;
        logic standby_ctl;
    } col_ctrl_t;

    typedef struct packed {
        logic [1:0] catchup_exit_delay_sel;
        logic [1:0] catchup_gain_sel;
    } col_loop_t;

endpackage : col_pkg

// file: hw/col_offset_loop.sv
// offset feedback loop and digital output formatter behind an ahb-lite register slave
//
// What this block does
// - each black period, measure offset from own samples and steer the current dac
// - writing a new gain value enters the fast catch-up state
// - two-bit catch-up field picks loop multiplier 4, 8, 16 or 32
// - catch-up persists while offset error exceeds 32 lsb
// - at or below 32 lsb, return to normal after 1, 2, 4 or 8 lines
// - one line equals one full cycle of the black pulse input
// - while pre-blanking, isolate sampling and output the clamp code
// - standby floats all ten outputs and enters low power, overriding everything
// - top-bit invert flips only output bit 9
// - low-bits invert flips bits 8..0; both together flip all ten
// - code select low gives straight binary, high gives gray code
// - test pattern bit drives the fixed pattern regardless of pre-blanking
// - standby, test and inverts from registers; pre-blank from pin, polarity by register
// - black window is clocks 5 to 12 after the pulse, eight samples averaged
// - output updates ten clocks after sampling, nine in direct input mode
// - clamp code is register programmable
`timescale 1ns/100ps

module col_offset_loop (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // converter side
    input  wire logic [9:0]  adc_sample,
    input  wire logic        black_pulse_in,
    input  wire logic        preblank_in,
    output logic      [11:0] dac_code,
    output logic             sample_isolate,
    output logic             low_power,
    output logic      [7:0]  pga_gain,
    // downstream processor
    output logic      [9:0]  data_out,
    output logic             data_oe
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic signed [15:0] sat_dac(input logic signed [16:0] v);
        if (v > 17'(DAC_MAX_EXT()))
            return col_pkg::DAC_MAX;
        else if (v < -17'sh00800)
            return col_pkg::DAC_MIN;
        else
            return v[15:0];
    endfunction : sat_dac

    function automatic logic signed [16:0] DAC_MAX_EXT();
        return {col_pkg::DAC_MAX[15], col_pkg::DAC_MAX};
    endfunction : DAC_MAX_EXT

    function automatic logic [10:0] abs_err(input logic signed [10:0] e);
        return e[10] ? 11'(-e) : 11'(e);
    endfunction : abs_err

    // ************************************************************
    // register file and bus slave
    // ************************************************************
    col_pkg::col_ctrl_t       ctrl_ff;
    col_pkg::col_loop_t       loop_ff;
    logic [7:0]               gain_ff;
    logic [9:0]               clamp_ff;
    logic                     wr_pend_ff;
    logic                     rd_pend_ff;
    logic [7:0]               addr_ff;
    logic                     gain_new_ff;
    logic [31:0]              nxt_rdata;
    logic                     accept;
    col_pkg::col_loop_state_t state_ff;
    logic signed [10:0]       err_ff;
    logic signed [15:0]       acc_ff;

    assign accept = hsel & htrans[1] & hready;

    // address phase capture; reads take one wait state so a preceding write lands first
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
        else
        begin
            wr_pend_ff <= accept & hwrite;
            rd_pend_ff <= accept & ~hwrite;
            if (accept)
                addr_ff <= haddr;
            hreadyout  <= ~(accept & ~hwrite);
            hresp      <= 1'b0;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case (addr_ff)
            col_pkg::ADDR_CTRL:   nxt_rdata = {25'h0, ctrl_ff};
            col_pkg::ADDR_LOOP:   nxt_rdata = {28'h0, loop_ff};
            col_pkg::ADDR_GAIN:   nxt_rdata = {24'h0, gain_ff};
            col_pkg::ADDR_CLAMP:  nxt_rdata = {22'h0, clamp_ff};
            col_pkg::ADDR_STATUS:
            begin
                nxt_rdata[1:0] = state_ff;
                nxt_rdata[col_pkg::STAT_ERR_LSB +: 11] = err_ff;
                nxt_rdata[col_pkg::STAT_DAC_LSB +: 12] = acc_ff[11:0];
            end
            default:              nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            hrdata <= 32'h0000_0000;
        else if (rd_pend_ff)
            hrdata <= nxt_rdata;
    end

    // register writes in the data phase
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_ff     <= col_pkg::CTRL_RESET;
            loop_ff     <= col_pkg::LOOP_RESET;
            gain_ff     <= col_pkg::GAIN_RESET;
            clamp_ff    <= col_pkg::CLAMP_RESET;
            gain_new_ff <= 1'b0;
        end
        else
        begin
            gain_new_ff <= 1'b0;
            if (wr_pend_ff)
            begin
                case (addr_ff)
                    col_pkg::ADDR_CTRL:  ctrl_ff  <= hwdata[6:0];
                    col_pkg::ADDR_LOOP:  loop_ff  <= hwdata[3:0];
                    col_pkg::ADDR_CLAMP: clamp_ff <= hwdata[9:0];
                    col_pkg::ADDR_GAIN:
                    begin
                        gain_ff     <= hwdata[7:0];
                        gain_new_ff <= (hwdata[7:0] != gain_ff);
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            pga_gain <= col_pkg::GAIN_RESET;
        else
            pga_gain <= gain_ff;
    end

    // ************************************************************
    // pre-blank and standby
    // ************************************************************
    logic preblank_act;

    // pin level is active low unless the polarity bit is set
    assign preblank_act = ctrl_ff.preblank_pol_inv ? preblank_in : ~preblank_in;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sample_isolate <= 1'b0;
            low_power      <= 1'b1;
        end
        else
        begin
            sample_isolate <= preblank_act;
            low_power      <= ctrl_ff.standby_ctl;
        end
    end

    // ************************************************************
    // black window measurement
    // ************************************************************
    logic        bp_prev_ff;
    logic [3:0]  ob_cnt_ff;
    logic [12:0] ob_sum_ff;
    logic        ob_done_ff;
    logic        bp_rise;
    logic signed [10:0] nxt_err;

    assign bp_rise = black_pulse_in & ~bp_prev_ff;

    // clock counter after each pulse; a line is one pulse cycle
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bp_prev_ff <= 1'b0;
            ob_cnt_ff  <= 4'h0;
            ob_done_ff <= 1'b0;
        end
        else
        begin
            bp_prev_ff <= black_pulse_in;
            ob_done_ff <= (ob_cnt_ff == col_pkg::OB_LAST_CLK);
            if (bp_rise)
                ob_cnt_ff <= 4'h1;
            else if (ob_cnt_ff == col_pkg::OB_LAST_CLK)
                ob_cnt_ff <= 4'h0;
            else if (ob_cnt_ff != 4'h0)
                ob_cnt_ff <= ob_cnt_ff + 4'h1;
        end
    end

    // eight black samples summed; isolated samples during pre-blank are skipped
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            ob_sum_ff <= 13'h0000;
        else if (bp_rise)
            ob_sum_ff <= 13'h0000;
        else if (ob_cnt_ff >= col_pkg::OB_FIRST_CLK && !preblank_act)
            ob_sum_ff <= ob_sum_ff + {3'h0, adc_sample};
    end

    // average minus the programmed clamp reference
    assign nxt_err = 11'(signed'({1'b0, ob_sum_ff[12:col_pkg::OB_AVG_SHIFT]}))
                   - 11'(signed'({1'b0, clamp_ff}));

    // ************************************************************
    // catch-up state and dac loop
    // ************************************************************
    logic [3:0]  exit_cnt_ff;
    logic [3:0]  exit_lines;
    logic [2:0]  step_shift;
    logic        err_big;
    logic signed [16:0] step;

    assign err_big    = abs_err(nxt_err) > col_pkg::ERR_THRESHOLD;
    // 1, 2, 4 or 8 lines
    assign exit_lines = 4'h1 << loop_ff.catchup_exit_delay_sel;
    // multiplier 4, 8, 16 or 32 as a shift of 2..5; none in normal gain
    assign step_shift = (state_ff == col_pkg::ST_NORMAL) ? 3'h0
                      : 3'(3'h2 + {1'b0, loop_ff.catchup_gain_sel});
    assign step       = 17'(signed'(nxt_err)) <<< step_shift;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff    <= col_pkg::ST_NORMAL;
            exit_cnt_ff <= 4'h0;
        end
        else if (gain_new_ff)
        begin
            state_ff    <= col_pkg::ST_CATCHUP;
            exit_cnt_ff <= 4'h0;
        end
        else if (ob_done_ff)
        begin
            case (state_ff)
                col_pkg::ST_NORMAL: ;
                col_pkg::ST_CATCHUP:
                begin
                    if (!err_big)
                    begin
                        state_ff    <= col_pkg::ST_EXIT;
                        exit_cnt_ff <= 4'h1;
                    end
                end
                col_pkg::ST_EXIT:
                begin
                    if (err_big)
                    begin
                        state_ff    <= col_pkg::ST_CATCHUP;
                        exit_cnt_ff <= 4'h0;
                    end
                    else if (exit_cnt_ff >= exit_lines)
                    begin
                        state_ff    <= col_pkg::ST_NORMAL;
                        exit_cnt_ff <= 4'h0;
                    end
                    else
                        exit_cnt_ff <= exit_cnt_ff + 4'h1;
                end
                default: state_ff <= col_pkg::ST_NORMAL;
            endcase
        end
    end

    // one update per line pulls the black level toward the reference
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_ff <= 16'sh0000;
            err_ff <= 11'sh000;
        end
        else if (ob_done_ff)
        begin
            acc_ff <= sat_dac(17'(signed'(acc_ff)) - step);
            err_ff <= nxt_err;
        end
    end

    // offset binary for the current dac
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            dac_code <= col_pkg::DAC_MID;
        else
            dac_code <= acc_ff[11:0] ^ col_pkg::DAC_MID;
    end

    // ************************************************************
    // output pipeline and formatting
    // ************************************************************
    logic [9:0] pipe_ff [0:col_pkg::PIPE_DEPTH-1];
    logic [9:0] tap;
    logic [9:0] coded;
    logic [9:0] inv_mask;
    logic [9:0] nxt_data;

    // latency chain; the output flop is one more stage after the tapped entry
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < col_pkg::PIPE_DEPTH; i++)
                pipe_ff[i] <= 10'h000;
        end
        else
        begin
            pipe_ff[0] <= adc_sample;
            for (int i = 1; i < col_pkg::PIPE_DEPTH; i++)
                pipe_ff[i] <= pipe_ff[i-1];
        end
    end

    // ten clocks in correlated mode, nine in direct mode
    assign tap = ctrl_ff.direct_mode ? pipe_ff[col_pkg::TAP_DIRECT]
                                     : pipe_ff[col_pkg::TAP_CORR];

    always_comb
    begin
        coded    = ctrl_ff.gray_code_sel ? (tap ^ (tap >> 1)) : tap;
        inv_mask = (ctrl_ff.top_bit_invert  ? col_pkg::TOP_MASK : 10'h000)
                 | (ctrl_ff.low_bits_invert ? col_pkg::LOW_MASK : 10'h000);
        nxt_data = coded ^ inv_mask;
        if (ctrl_ff.test_pattern_sel)
            nxt_data = col_pkg::TEST_PATTERN;
        else if (preblank_act)
            nxt_data = clamp_ff;
        if (ctrl_ff.standby_ctl)
            nxt_data = 10'h000;
    end

    // standby floats the bus; driven data parked at zero meanwhile
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_out <= 10'h000;
            data_oe  <= 1'b0;
        end
        else
        begin
            data_out <= nxt_data;
            data_oe  <= ~ctrl_ff.standby_ctl;
        end
    end

endmodule : col_offset_loop

// file: tb/col_sva.sv
// checker: bus handshake, gain copy, dac update timing and standby output
`timescale 1ns/100ps
module col_sva (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // register bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // converter side and stream
    input wire logic [9:0]  adc_sample,
    input wire logic        black_pulse_in,
    input wire logic        preblank_in,
    input wire logic [11:0] dac_code,
    input wire logic        sample_isolate,
    input wire logic        low_power,
    input wire logic [7:0]  pga_gain,
    input wire logic [9:0]  data_out,
    input wire logic        data_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic       ob_prev_ff;
    logic [4:0] since_ob_ff;
    wire  logic take = hsel && htrans[1] && hready;

    // cycles since the last black pulse rise, saturating so idle lines stay large
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ob_prev_ff  <= 1'b0;
            since_ob_ff <= 5'h1f;
        end
        else
        begin
            ob_prev_ff <= black_pulse_in;
            if (black_pulse_in && !ob_prev_ff)
                since_ob_ff <= 5'h00;
            else if (since_ob_ff != 5'h1f)
                since_ob_ff <= since_ob_ff + 5'h01;
        end
    end

    sequence s_rd_take;
        take && !hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    a_resp_always_okay: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_read_one_wait: assert property (s_rd_take |=> s_one_wait)
        else $error("read wait not one cycle");
    a_ready_low_single: assert property (!hreadyout |=> hreadyout)
        else $error("ready low too long");
    a_rdata_read_only: assert property ($changed(hrdata) |-> $past(take && !hwrite, 2))
        else $error("read data moved without a read");
    a_gain_from_write: assert property ($changed(pga_gain) |-> $past(take && hwrite && haddr == col_pkg::ADDR_GAIN, 3))
        else $error("gain moved without a gain write");
    a_dac_line_update: assert property ($changed(dac_code) |-> since_ob_ff >= 5'd8 && since_ob_ff <= 5'd24)
        else $error("dac moved outside the black period update");
    a_standby_quiet: assert property (!data_oe |-> data_out == 10'h000)
        else $error("output not quiet while disabled");
endmodule : col_sva

bind col_offset_loop col_sva u_sva (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .adc_sample, .black_pulse_in, .preblank_in, .dac_code, .sample_isolate,
    .low_power, .pga_gain, .data_out, .data_oe);

// file: tb/col_dsp_model.sv
// downstream processor model: drives the pre-blank pin and takes output words
`timescale 1ns/100ps
module col_dsp_model (
    // clock
    input  wire logic       sys_clk,
    // pre-blank request and pin polarity
    input  wire logic       blank_req,
    input  wire logic       blank_high,
    // sample stream
    input  wire logic [9:0] data_out,
    input  wire logic       data_oe,
    output logic            preblank_in = 1'b1,
    output logic      [9:0] rx_word = 10'h000
);
    // pin level follows the polarity the processor was set up for
    always @(posedge sys_clk)
    begin
        preblank_in <= blank_high ? blank_req : !blank_req;
    end
    // words are only taken while the converter drives the bus
    always @(posedge sys_clk)
    begin
        if (data_oe)
            rx_word <= data_out;
    end
endmodule : col_dsp_model

// file: tb/tb_top.sv
// top-level bench: register access, output stream, pre-blank and offset loop
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, preblank_in, sample_isolate, low_power, data_oe;
    logic        black_pulse_in = 1'b0;
    logic        hold = 1'b0;
    logic        blank_req = 1'b0;
    logic        blank_high = 1'b0;
    logic [9:0]  adc_sample = 10'h000;
    logic [9:0]  hold_val = 10'h000;
    logic [9:0]  data_out, rx_word;
    logic [9:0]  hist [0:15];
    logic [3:0]  cyc = 4'h0;
    logic [11:0] dac_code;
    logic [7:0]  pga_gain;
    int          err_count = 0;
    int          checks_done = 0;
    int          acc = 0;

    always #5 sys_clk = ~sys_clk;

    col_offset_loop dut (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .adc_sample, .black_pulse_in, .preblank_in,
        .dac_code, .sample_isolate, .low_power, .pga_gain, .data_out, .data_oe);
    col_dsp_model u_dsp (.sys_clk, .blank_req, .blank_high, .data_out, .data_oe, .preblank_in, .rx_word);

    // sample source: a stepping ramp, or a held level for the loop tests
    always @(posedge sys_clk)
    begin
        hist[cyc] <= adc_sample;
        cyc <= cyc + 4'h1;
        adc_sample <= hold ? hold_val : adc_sample + 10'h025;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one single transfer; waits on ready, read data taken at the last edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask : rdchk

    task automatic line;
        @(posedge sys_clk);
        black_pulse_in <= 1'b1;
        repeat (4) @(posedge sys_clk);
        black_pulse_in <= 1'b0;
        repeat (36) @(posedge sys_clk);
    endtask : line

    function automatic logic [9:0] fmt(input logic [9:0] x, input logic [2:0] m);
        logic [9:0] y;
        y = m[0] ? x ^ (x >> 1) : x;
        if (m[2]) y = y ^ 10'h200;
        if (m[1]) y = y ^ 10'h1ff;
        return y;
    endfunction : fmt

    // the receiver's word lags the pin by one edge
    task automatic stream(input logic [2:0] m, input logic dir, input int lat);
        bus(1'b1, 8'h00, {25'h0, dir, 1'b0, m, 2'b00});
        repeat (12) @(posedge sys_clk);
        repeat (8)
        begin
            @(posedge sys_clk);
            #1;
            chk("rx_word", {22'h0, fmt(hist[cyc - 4'd2 - lat[3:0]], m)}, {22'h0, rx_word});
        end
    endtask : stream

    // the pin is read after the wait, not when the task is called
    task automatic pin_chk(input string nm, input logic [9:0] exp);
        logic [9:0] got;
        repeat (4) @(posedge sys_clk);
        #1;
        got = (nm == "data_out") ? data_out : {9'h0, (nm == "isolate") ? sample_isolate : low_power};
        chk(nm, {22'h0, exp}, {22'h0, got});
    endtask : pin_chk

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        print_verdict;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        rdchk("ctrl", 8'h00, 32'h1);
        rdchk("loop", 8'h04, 32'h0);
        rdchk("gain", 8'h08, 32'h0);
        rdchk("clamp", 8'h0c, 32'h40);
        rdchk("unmapped", 8'h14, 32'h0);
        chk("data_oe", 32'h0, {31'h0, data_oe});
        for (int m = 0; m < 8; m++)
            stream(m[2:0], 1'b0, 10);
        stream(3'b101, 1'b1, 9);
        bus(1'b1, 8'h0c, 32'h4c);
        bus(1'b1, 8'h00, 32'h1c);
        blank_req <= 1'b1;
        pin_chk("data_out", 10'h04c);
        pin_chk("isolate", 10'h001);
        bus(1'b1, 8'h00, 32'h1e);
        pin_chk("data_out", 10'h355);
        bus(1'b1, 8'h00, 32'h20);
        for (int p = 0; p < 2; p++)
        begin
            blank_high <= p[0];
            pin_chk("isolate", {9'h0, p[0]});
        end
        bus(1'b1, 8'h00, 32'h03);
        pin_chk("low_power", 10'h001);
        chk("data_oe", 32'h0, {31'h0, data_oe});
        blank_req <= 1'b0;
        blank_high <= 1'b0;
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h0c, 32'h40);
        hold <= 1'b1;
        hold_val <= 10'h068;
        bus(1'b1, 8'h08, 32'h10);
        rdchk("state", 8'h10, 32'h1);
        chk("pga_gain", 32'h10, {24'h0, pga_gain});
        for (int g = 0; g < 4; g++)
        begin
            bus(1'b1, 8'h04, g);
            line();
            acc = acc - (40 << (2 + g));
            if (acc < -2048) acc = -2048;
            chk("dac_code", 32'(2048 + acc), {20'h0, dac_code});
            bus(1'b0, 8'h10, 32'h0);
            chk("state", 32'h1, {30'h0, rd[1:0]});
        end
        hold_val <= 10'h060;
        for (int e = 0; e < 4; e++)
        begin
            bus(1'b1, 8'h04, {28'h0, e[1:0], 2'b00});
            bus(1'b1, 8'h08, 32'h20 + e);
            repeat (1 << e) line();
            bus(1'b0, 8'h10, 32'h0);
            chk("state", 32'h2, {30'h0, rd[1:0]});
            line();
            bus(1'b0, 8'h10, 32'h0);
            chk("state", 32'h0, {30'h0, rd[1:0]});
        end
        bus(1'b1, 8'h08, 32'h23);
        // same gain value: no catch-up; status holds normal state, last error 32, saturated accumulator
        rdchk("state", 8'h10, {4'h0, 12'(acc), 1'b0, 11'd32, 4'h0});
        print_verdict;
    end
endmodule : tb_top
